// ### src/maf_pkg.sv
// constants and helpers shared by the address filter design files
package maf_pkg;

  // register byte addresses
  localparam logic [31:0] CMD_ADDR = 32'hB000_3000;
  localparam logic [31:0] ENABLE_ADDR = 32'hB000_3004;
  localparam logic [31:0] ENTRY0_UPPER_ADDR = 32'hB000_3008;
  localparam logic [31:0] ENTRY0_LOWER_ADDR = 32'hB000_300C;
  localparam logic [31:0] ENTRY15_UPPER_ADDR = 32'hB000_3080;
  localparam logic [31:0] ENTRY15_LOWER_ADDR = 32'hB000_3084;
  localparam logic [31:0] MAC_CMD_ADDR = 32'hB000_3090;

  // reset values
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
  localparam logic [31:0] MAC_CMD_RESET = 32'h0000_0000;

  // command register field positions
  localparam int CMD_FALLING_EDGE_BIT = 5;
  localparam int CMD_COMPARE_BIT = 4;
  localparam int CMD_COMPLEMENT_BIT = 3;
  localparam int CMD_BROADCAST_BIT = 2;
  localparam int CMD_MULTICAST_BIT = 1;
  localparam int CMD_UNICAST_BIT = 0;
  localparam logic [31:0] CMD_MASK = 32'h0000_003F;
  localparam logic [31:0] ENABLE_MASK = 32'h0000_FFFF;
  localparam int SEND_PAUSE_BIT = 16;

  // entry organisation
  localparam int ENTRY_COUNT = 16;
  localparam int WORD_COUNT = 32;
  localparam logic [3:0] LAST_MATCH_ENTRY = 4'd12;
  localparam logic [4:0] PAUSE_FIRST_WORD = 5'd26;
  localparam int PAUSE_WORDS = 6;
  localparam int ADDR_BYTES = 6;

  // line coding on the reduced interface
  localparam logic [1:0] PREAMBLE_DIBIT = 2'b01;
  localparam logic [1:0] SFD_DIBIT = 2'b11;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // register classes seen by the bus decoder
  typedef enum logic [2:0] {
    maf_kind_cmd, maf_kind_enable, maf_kind_entry, maf_kind_mac, maf_kind_none
  } maf_kind_t;

  // merge written bytes into an old word under the byte strobes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ### src/maf_entry_mem.sv
// address entry storage: one write port, one bus read port, one scan read port
`timescale 1ns/1ps
`default_nettype none
module maf_entry_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic [4:0] bus_rd_idx,
  output logic [31:0] bus_rd_data,
  input wire logic [3:0] scan_idx,
  output logic [31:0] scan_upper,
  output logic [31:0] scan_lower
);

  logic [31:0] words [maf_pkg::WORD_COUNT];

  ////////////////////////////////////////////////////////////////////////////
  // storage; cleared on reset so every entry starts at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < maf_pkg::WORD_COUNT; i++) begin
        words[i] <= maf_pkg::ENTRY_RESET;
      end
    end else if (wr_en) begin
      words[wr_idx] <= maf_pkg::merge_bytes(words[wr_idx], wr_data, wr_strb);
    end
  end

  // registered reads; the scan port reads both words of an entry at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_rd_data <= maf_pkg::ENTRY_RESET;
      scan_upper <= maf_pkg::ENTRY_RESET;
      scan_lower <= maf_pkg::ENTRY_RESET;
    end else begin
      bus_rd_data <= words[bus_rd_idx];
      scan_upper <= words[{scan_idx, 1'b0}];
      scan_lower <= words[{scan_idx, 1'b1}];
    end
  end

endmodule
`default_nettype wire

// ### src/maf_filter.sv
// receive destination address filter with sixteen entries and pause fields
`timescale 1ns/1ps
`default_nettype none
module maf_filter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ref_clk_in,
  input wire logic phy_carrier_valid_input,
  input wire logic [1:0] phy_receive_data_input,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic rx_frame_accept,
  output logic rx_frame_reject,
  output logic [47:0] rx_dest_addr,
  output logic send_pause_command,
  input wire logic pause_sent,
  output logic [47:0] pause_dest_addr,
  output logic [47:0] pause_src_addr,
  output logic [15:0] pause_length_type,
  output logic [15:0] pause_opcode,
  output logic [15:0] pause_operand
);

  typedef enum logic [2:0] {
    maf_rx_idle, maf_rx_preamble, maf_rx_addr, maf_rx_decide, maf_rx_pass, maf_rx_drop
  } maf_rx_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // classify a register address; unaligned or unknown addresses get none
  function automatic maf_pkg::maf_kind_t decode(input logic [31:0] addr);
    if (addr == maf_pkg::CMD_ADDR) begin
      return maf_pkg::maf_kind_cmd;
    end else if (addr == maf_pkg::ENABLE_ADDR) begin
      return maf_pkg::maf_kind_enable;
    end else if (addr == maf_pkg::MAC_CMD_ADDR) begin
      return maf_pkg::maf_kind_mac;
    end else if (addr >= maf_pkg::ENTRY0_UPPER_ADDR && addr <= maf_pkg::ENTRY15_LOWER_ADDR
                 && addr[1:0] == 2'b00) begin
      return maf_pkg::maf_kind_entry;
    end
    return maf_pkg::maf_kind_none;
  endfunction

  // word index inside the entry storage: even = upper word, odd = lower word
  function automatic logic [4:0] word_index(input logic [31:0] addr);
    logic [31:0] diff;
    diff = addr - maf_pkg::ENTRY0_UPPER_ADDR;
    return diff[6:2];
  endfunction

  // acceptance over the five command bits and the frame class
  function automatic logic accept_frame(input logic [5:0] cmd, input logic hit,
                                        input logic bcast, input logic mcast);
    logic ucast;
    logic cam_term;
    ucast = !bcast && !mcast;
    // complement alone opens the filter; with compare on it inverts the match
    cam_term = cmd[maf_pkg::CMD_COMPARE_BIT] ?
               (hit ^ cmd[maf_pkg::CMD_COMPLEMENT_BIT]) :
               cmd[maf_pkg::CMD_COMPLEMENT_BIT];
    return cam_term
        || (cmd[maf_pkg::CMD_COMPLEMENT_BIT] && cmd[maf_pkg::CMD_UNICAST_BIT])
        || (cmd[maf_pkg::CMD_BROADCAST_BIT] && bcast)
        || (cmd[maf_pkg::CMD_MULTICAST_BIT] && mcast)
        || (cmd[maf_pkg::CMD_UNICAST_BIT] && ucast);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus: write channel

  logic aw_held;
  logic [31:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  maf_pkg::maf_kind_t wr_kind;
  logic [4:0] wr_idx;
  logic [5:0] cmd;
  logic [15:0] entry_enable;
  logic [31:0] pause_words [maf_pkg::PAUSE_WORDS];

  assign awready = !aw_held;
  assign wready = !w_held;
  // a write goes through once both halves are held and the last answer is gone
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_kind = decode(aw_addr);
  assign wr_idx = word_index(aw_addr);

  // address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= maf_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (wr_kind == maf_pkg::maf_kind_none) ? maf_pkg::RESP_SLVERR : maf_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // command and enable registers; only the documented bits are kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd <= maf_pkg::CMD_RESET[5:0];
      entry_enable <= maf_pkg::ENABLE_RESET[15:0];
    end else if (do_write) begin
      if (wr_kind == maf_pkg::maf_kind_cmd) begin
        cmd <= 6'(maf_pkg::merge_bytes({26'h0, cmd}, w_data, w_strb) & maf_pkg::CMD_MASK);
      end
      if (wr_kind == maf_pkg::maf_kind_enable) begin
        entry_enable <= 16'(maf_pkg::merge_bytes({16'h0, entry_enable}, w_data, w_strb)
                            & maf_pkg::ENABLE_MASK);
      end
    end
  end

  // send-pause bit: hardware clears it when the frame has gone out, but a
  // software set in the same cycle wins so a fresh request is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      send_pause_command <= maf_pkg::MAC_CMD_RESET[maf_pkg::SEND_PAUSE_BIT];
    end else if (do_write && wr_kind == maf_pkg::maf_kind_mac && w_strb[2]) begin
      send_pause_command <= w_data[maf_pkg::SEND_PAUSE_BIT]
                            || (send_pause_command && !pause_sent);
    end else if (pause_sent) begin
      send_pause_command <= 1'b0;
    end
  end

  // shadow copy of entries 13 to 15 so the transmit side sees them as flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < maf_pkg::PAUSE_WORDS; i++) begin
        pause_words[i] <= maf_pkg::ENTRY_RESET;
      end
    end else if (do_write && wr_kind == maf_pkg::maf_kind_entry
                 && wr_idx >= maf_pkg::PAUSE_FIRST_WORD) begin
      pause_words[3'(wr_idx - maf_pkg::PAUSE_FIRST_WORD)] <=
        maf_pkg::merge_bytes(pause_words[3'(wr_idx - maf_pkg::PAUSE_FIRST_WORD)],
                             w_data, w_strb);
    end
  end

  // pause frame fields: entry 13 destination, 14 source, 15 control fields
  assign pause_dest_addr = {pause_words[0], pause_words[1][31:16]};
  assign pause_src_addr = {pause_words[2], pause_words[3][31:16]};
  assign pause_length_type = pause_words[4][31:16];
  assign pause_opcode = pause_words[4][15:0];
  assign pause_operand = pause_words[5][31:16];

  ////////////////////////////////////////////////////////////////////////////
  // register bus: read channel

  logic rd_busy;
  maf_pkg::maf_kind_t rd_kind;
  logic [31:0] mem_rd_data;
  logic [3:0] scan_idx;
  logic [31:0] scan_upper;
  logic [31:0] scan_lower;

  assign arready = !rd_busy && !rvalid;

  // one read at a time: the storage answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_busy <= 1'b0;
      rd_kind <= maf_pkg::maf_kind_none;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= maf_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rd_busy <= 1'b1;
      rd_kind <= decode(araddr);
    end else if (rd_busy) begin
      rd_busy <= 1'b0;
      rvalid <= 1'b1;
      rresp <= maf_pkg::RESP_OKAY;
      unique case (rd_kind)
        maf_pkg::maf_kind_cmd: rdata <= {26'h0, cmd};
        maf_pkg::maf_kind_enable: rdata <= {16'h0, entry_enable};
        maf_pkg::maf_kind_entry: rdata <= mem_rd_data;
        maf_pkg::maf_kind_mac: rdata <= {15'h0, send_pause_command, 16'h0};
        maf_pkg::maf_kind_none: begin
          rdata <= 32'h0000_0000;
          rresp <= maf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  maf_entry_mem u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(do_write && wr_kind == maf_pkg::maf_kind_entry),
    .wr_idx(wr_idx),
    // reserved low half of a lower word is never stored, so it reads back zero
    .wr_data({w_data[31:16], wr_idx[0] ? 16'h0000 : w_data[15:0]}),
    .wr_strb(w_strb),
    .bus_rd_idx(word_index(araddr)),
    .bus_rd_data(mem_rd_data),
    .scan_idx(scan_idx),
    .scan_upper(scan_upper),
    .scan_lower(scan_lower)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reduced-interface receive sampling

  logic ref_q;
  logic sample;
  logic crs;
  logic [1:0] rxd;
  logic in_frame;
  logic [1:0] dibit_cnt;
  logic [7:0] byte_sr;
  logic byte_done;
  logic [7:0] byte_val;
  maf_rx_state_t rx_state;

  // edge of the reference clock chosen by the command bit; this needs aclk
  // well above the reference rate, a trade for keeping a single clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_clk_in;
    end
  end
  assign sample = cmd[maf_pkg::CMD_FALLING_EDGE_BIT] ? (ref_q && !ref_clk_in)
                                                     : (!ref_q && ref_clk_in);
  assign crs = phy_carrier_valid_input;
  assign rxd = phy_receive_data_input;
  assign in_frame = rx_state inside {maf_rx_addr, maf_rx_decide, maf_rx_pass, maf_rx_drop};

  // byte assembly after the delimiter; first dibit lands in the low bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dibit_cnt <= 2'd0;
      byte_sr <= 8'h00;
      byte_done <= 1'b0;
      byte_val <= 8'h00;
    end else begin
      byte_done <= 1'b0;
      if (!in_frame) begin
        dibit_cnt <= 2'd0;
      end else if (sample && crs) begin
        byte_sr <= {rxd, byte_sr[7:2]};
        dibit_cnt <= dibit_cnt + 2'd1;
        if (dibit_cnt == 2'd3) begin
          byte_done <= 1'b1;
          byte_val <= {rxd, byte_sr[7:2]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame state and entry scan

  logic [2:0] addr_bytes;
  logic scan_run;
  logic scan_chk;
  logic [3:0] chk_idx;
  logic scan_fin;
  logic hit;
  logic is_bcast;
  logic is_mcast;

  assign is_bcast = &rx_dest_addr;
  assign is_mcast = rx_dest_addr[40] && !is_bcast;

  // frame sequencing: preamble, delimiter, six address bytes, decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= maf_rx_idle;
      addr_bytes <= 3'd0;
      rx_dest_addr <= 48'h0000_0000_0000;
      rx_frame_accept <= 1'b0;
      rx_frame_reject <= 1'b0;
    end else begin
      rx_frame_accept <= 1'b0;
      rx_frame_reject <= 1'b0;
      if (sample && !crs) begin
        rx_state <= maf_rx_idle;  // carrier gone ends the frame in any state
      end else begin
        unique case (rx_state)
          maf_rx_idle: begin
            if (sample && rxd == maf_pkg::PREAMBLE_DIBIT) begin
              rx_state <= maf_rx_preamble;
            end
          end
          maf_rx_preamble: begin
            if (sample && rxd == maf_pkg::SFD_DIBIT) begin
              rx_state <= maf_rx_addr;
              addr_bytes <= 3'd0;
            end
          end
          maf_rx_addr: begin
            if (byte_done) begin
              rx_dest_addr <= {rx_dest_addr[39:0], byte_val};
              addr_bytes <= addr_bytes + 3'd1;
              if (addr_bytes == 3'(maf_pkg::ADDR_BYTES - 1)) begin
                rx_state <= maf_rx_decide;
              end
            end
          end
          maf_rx_decide: begin
            if (scan_fin) begin
              if (accept_frame(cmd, hit, is_bcast, is_mcast)) begin
                rx_state <= maf_rx_pass;
                rx_frame_accept <= 1'b1;
              end else begin
                rx_state <= maf_rx_drop;
                rx_frame_reject <= 1'b1;
              end
            end
          end
          maf_rx_pass: rx_state <= maf_rx_pass;
          maf_rx_drop: rx_state <= maf_rx_drop;
        endcase
      end
    end
  end

  // scan the recognition entries one per cycle; pause entries are skipped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_run <= 1'b0;
      scan_idx <= 4'd0;
      scan_chk <= 1'b0;
      chk_idx <= 4'd0;
      scan_fin <= 1'b0;
      hit <= 1'b0;
    end else begin
      scan_chk <= scan_run;
      chk_idx <= scan_idx;
      scan_fin <= scan_chk && chk_idx == maf_pkg::LAST_MATCH_ENTRY;
      if (rx_state == maf_rx_addr && byte_done
          && addr_bytes == 3'(maf_pkg::ADDR_BYTES - 1)) begin
        scan_run <= 1'b1;
        scan_idx <= 4'd0;
        hit <= 1'b0;
      end else if (scan_run) begin
        if (scan_idx == maf_pkg::LAST_MATCH_ENTRY) begin
          scan_run <= 1'b0;
        end
        scan_idx <= scan_idx + 4'd1;
      end
      if (scan_chk && entry_enable[chk_idx]
          && {scan_upper, scan_lower[31:16]} == rx_dest_addr) begin
        hit <= 1'b1;
      end
    end
  end

  // only frames that passed the filter reach the receive side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_byte <= 8'h00;
      rx_byte_valid <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      if (rx_state == maf_rx_pass && byte_done && !(sample && !crs)) begin
        rx_byte <= byte_val;
        rx_byte_valid <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### bench/maf_filter_asserts.sv
// concurrent checks bound to the address filter top
`timescale 1ns/1ps
`default_nettype none
module maf_filter_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rx_byte_valid,
  input wire logic rx_frame_accept,
  input wire logic rx_frame_reject,
  input wire logic send_pause_command,
  input wire logic pause_sent
);
  logic pass;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // pass state: bytes may only flow between an accept and the next reject
  always_ff @(posedge aclk) begin
    if (!aresetn) pass <= 1'b0;
    else if (rx_frame_accept) pass <= 1'b1;
    else if (rx_frame_reject) pass <= 1'b0;
  end
  //////////////////////////////////////////////////////////////
  a_verdict_once: assert property (!(rx_frame_accept && rx_frame_reject))
    else $error("accept and reject together");
  a_accept_pulse: assert property (rx_frame_accept |=> !rx_frame_accept)
    else $error("accept longer than one cycle");
  a_bytes_gated: assert property (rx_byte_valid |-> pass)
    else $error("byte forwarded outside pass state");
  a_pause_clear: assert property (pause_sent && awready && wready |=> !send_pause_command)
    else $error("pause request not cleared");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_time: assert property (arvalid && arready |=> !rvalid ##1 rvalid)
    else $error("read answer off time");
  a_write_time: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer off time");
endmodule
bind maf_filter maf_filter_asserts u_chk (.*);
`default_nettype wire

// ### bench/maf_phy_model.sv
// behavioural reduced-interface receive phy feeding frames to the filter
`timescale 1ns/1ps
`default_nettype none
module maf_phy_model (
  output logic ref_clk_in,
  output logic phy_carrier_valid_input,
  output wire logic [1:0] phy_receive_data_input,
  input wire logic fall_edge
);
  logic [1:0] dat = 2'h0;
  logic [1:0] idle = 2'h0;
  initial ref_clk_in = 1'b0;
  initial phy_carrier_valid_input = 1'b0;
  // reference clock runs free, eight system cycles a period
  always #80 ref_clk_in = ~ref_clk_in;
  // idle data is meaningless, so keep it moving rather than parked
  always @(negedge ref_clk_in) idle <= idle + 2'h1;
  assign phy_receive_data_input = phy_carrier_valid_input ? dat : idle;
  //////////////////////////////////////////////////////////////
  // launch a quarter period after the edge the filter does not sample
  task automatic put(input logic [1:0] v, input logic c);
    if (fall_edge) @(posedge ref_clk_in);
    else @(negedge ref_clk_in);
    #40;
    phy_carrier_valid_input = c;
    dat = v;
    // spoil the dibit once sampled, so a filter on the wrong edge reads garbage
    #80 dat = ~v;
  endtask
  // preamble, delimiter, then bytes low dibit first
  task automatic send(input logic [47:0] d, input logic [15:0] p);
    logic [63:0] f;
    logic [7:0] b;
    f = {d, p};
    repeat (4) put(2'h1, 1'b1);
    put(2'h3, 1'b1);
    for (int i = 0; i < 8; i++) begin
      b = f[63 - 8 * i -: 8];
      for (int j = 0; j < 4; j++) put(b[2 * j +: 2], 1'b1);
    end
    put(2'h0, 1'b0);
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the address filter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, pause_sent = 1'b0, fall_edge = 1'b0;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, rx_byte_valid, rx_frame_accept;
  logic rx_frame_reject, send_pause_command, ref_clk_in, phy_carrier_valid_input;
  logic [1:0] bresp, rresp, phy_receive_data_input;
  logic [31:0] rdata;
  logic [7:0] rx_byte;
  logic [47:0] rx_dest_addr, pause_dest_addr, pause_src_addr;
  logic [15:0] pause_length_type, pause_opcode, pause_operand, seed = 16'hcc99;
  int errors = 0, checks_done = 0;
  logic [48:0] dq[$];
  logic [7:0] bq[$];
  logic [33:0] rq[$];
  localparam logic [47:0] AD [5] = '{48'hffff_ffff_ffff, 48'h0050_ba33_ba44,
    48'h0050_ba33_0002, 48'h0100_5e00_0001, 48'h0011_2233_4455};
  localparam int EN [6] = '{1, 2, 3, 13, 14, 15};
  localparam logic [31:0] UP [6] = '{32'h0050_ba33, 32'h0050_ba33, 32'h0100_5e00,
    32'h0011_2233, 32'h0050_ba33, 32'h8808_0001};
  localparam logic [31:0] LO [6] = '{32'hba44_ffff, 32'h0002_0000, 32'h0001_0000,
    32'h4455_0000, 32'hba44_0000, 32'h0200_0000};
  maf_filter dut (.*);
  maf_phy_model u_phy (.*);
  always #10 aclk = ~aclk;
  //////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [48:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // acceptance from the five command bits; only entries 1 and 3 are live
  function automatic logic acc_exp(input logic [4:0] c, input logic [47:0] d);
    logic cam;
    cam = c[4] ? (((d == AD[1]) || (d == AD[3])) ^ c[3]) : c[3];
    return cam | (c[3] & c[0]) | (c[2] & (&d))
        | (c[1] & d[40] & !(&d)) | (c[0] & !d[40]);
  endfunction
  // write: address and data offered together, bready held until bvalid is seen
  task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    check("bresp", bresp, r);
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic frame(input logic [47:0] d, input logic [4:0] c);
    seed = nxt(seed);
    dq.push_back({acc_exp(c, d), d});
    if (acc_exp(c, d)) begin
      bq.push_back(seed[15:8]);
      bq.push_back(seed[7:0]);
    end
    u_phy.send(d, seed);
    repeat (30) @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////
  // results are matched against the oldest note as they appear
  always @(posedge aclk) begin
    if (rvalid && rready) check("rdata", {rresp, rdata}, rq.pop_front());
    if (rx_frame_accept || rx_frame_reject) begin
      check("verdict", {rx_frame_accept, rx_dest_addr}, dq.pop_front());
    end
    if (rx_byte_valid) check("rx_byte", rx_byte, bq.pop_front());
  end
  initial begin
    #1_900_000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(maf_pkg::CMD_ADDR, 34'h0_0000_0000);
    rd(maf_pkg::ENTRY15_LOWER_ADDR, 34'h0_0000_0000);
    rd(32'hb000_3200, 34'h2_0000_0000);
    wr(32'hb000_3200, 32'hffff_ffff, 2'h2);
    // entries 13 to 15 carry the pause frame fields
    for (int k = 0; k < 6; k++) begin
      wr(maf_pkg::ENTRY0_UPPER_ADDR + 32'(8 * EN[k]), UP[k], 2'h0);
      wr(maf_pkg::ENTRY0_LOWER_ADDR + 32'(8 * EN[k]), LO[k], 2'h0);
    end
    rd(maf_pkg::ENTRY0_UPPER_ADDR + 32'h8, 34'h0_0050_ba33);
    rd(maf_pkg::ENTRY0_LOWER_ADDR + 32'h8, 34'h0_ba44_0000);
    wr(maf_pkg::ENABLE_ADDR, 32'hffff_e00a, 2'h0);
    rd(maf_pkg::ENABLE_ADDR, 34'h0_0000_e00a);
    check("length_type", pause_length_type, 16'h8808);
    check("opcode", pause_opcode, 16'h0001);
    check("operand", pause_operand, 16'h0200);
    check("pause_dest", pause_dest_addr, AD[4]);
    check("pause_src", pause_src_addr, AD[1]);
    wr(maf_pkg::MAC_CMD_ADDR, 32'h0001_0000, 2'h0);
    check("pause_req", send_pause_command, 1'b1);
    pause_sent <= 1'b1;
    @(posedge aclk);
    pause_sent <= 1'b0;
    @(posedge aclk);
    check("pause_req", send_pause_command, 1'b0);
    rd(maf_pkg::MAC_CMD_ADDR, 34'h0_0000_0000);
    // every command row, with a random sampling edge each time
    for (int i = 0; i < 32; i++) begin
      seed = nxt(seed);
      fall_edge = seed[0];
      wr(maf_pkg::CMD_ADDR, {26'h0, seed[0], i[4:0]}, 2'h0);
      rd(maf_pkg::CMD_ADDR, {28'h0, seed[0], i[4:0]});
      for (int k = 0; k < 6; k++) begin
        frame(k == 5 ? {8'h03, seed, seed, 8'h77} : AD[k], i[4:0]);
      end
    end
    check("queues", dq.size() + bq.size() + rq.size(), 0);
    stop_test();
  end
endmodule
`default_nettype wire
